// file: include/wdt_regs.svh
/*
 * watchdog interval timer: addresses, keys, field positions, reset values
 * and timing counts as macros.
 * assumes a 16-bit cpu address bus; included by its bare name.
 */
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// word write to the control address carries a key in the high byte
`define WDT_ADDR_CTRL 16'hffa4
`define WDT_ADDR_COUNT 16'hffa5
`define WDT_ADDR_RST_WR 16'hffa6
`define WDT_ADDR_RST_RD 16'hffa7
`define WDT_KEY_COUNT 8'h5a
`define WDT_KEY_CTRL 8'ha5
`define WDT_WD_OVERFLOW_FLAG_CLR_DATA 8'h00

// timer control/status field positions
`define WDT_CTRL_OVF_BIT 7
`define WDT_CTRL_MODE_BIT 6
`define WDT_CTRL_RUN_BIT 5
`define WDT_CTRL_FIXED 8'h18

// reset control/status field positions and reset value
`define WDT_RST_WD_OVERFLOW_FLAG_BIT 7
`define WDT_RST_CHIP_RESET_ENABLE_BIT 6
`define WDT_RSTCTL_RESET 8'h1f

// counter values
`define WDT_COUNT_ZERO 8'h00
`define WDT_COUNT_TOP 8'hff

// internal reset pulse length in peripheral clock cycles
`define WDT_RST_PULSE_CYCLES 10'h207

// prescaler terminal counts, divide ratio minus one
`define WDT_DIV2 17'h00001
`define WDT_DIV64 17'h0003f
`define WDT_DIV128 17'h0007f
`define WDT_DIV512 17'h001ff
`define WDT_DIV2048 17'h007ff
`define WDT_DIV8192 17'h01fff
`define WDT_DIV32768 17'h07fff
`define WDT_DIV131072 17'h1ffff

`endif

// file: include/wdt_pkg.sv
/*
 * watchdog interval timer: shared types.
 * assumes wdt_regs.svh holds all numeric constants.
 */
package wdt_pkg;

    // one cpu access as seen by the timer
    typedef struct packed {
        logic [15:0] addr;  // byte address
        logic wr;           // write strobe, one cycle
        logic rd;           // read strobe, one cycle
        logic word;         // 1 = 16-bit transfer
        logic [15:0] wdata; // write data, key in high byte
    } wdt_bus_req_t;

    // internal reset pulse generator, one-hot
    typedef enum logic [1:0] {
        WDT_PULSE_IDLE = 2'b01,
        WDT_PULSE_ACTIVE = 2'b10
    } wdt_pulse_state_t;

    typedef logic [2:0] wdt_cks_t;

endpackage : wdt_pkg

// file: rtl/wdt_prescaler.sv
/*
 * prescaler for the watchdog counter: divides the peripheral clock by
 * one of eight ratios and emits a one-cycle increment enable.
 * assumes run and select come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_prescaler
    import wdt_pkg::*;
(
    input wire logic clock,       // peripheral clock
    input wire logic resetn,      // async reset, active low
    input wire logic run,         // counting enabled
    input wire wdt_cks_t cks,     // divide select
    output logic tick             // one-cycle increment enable
);

    // terminal count for each select code
    function automatic logic [16:0] wdt_limit(input wdt_cks_t code);
        case (code)
            3'h0: wdt_limit = `WDT_DIV2;
            3'h1: wdt_limit = `WDT_DIV64;
            3'h2: wdt_limit = `WDT_DIV128;
            3'h3: wdt_limit = `WDT_DIV512;
            3'h4: wdt_limit = `WDT_DIV2048;
            3'h5: wdt_limit = `WDT_DIV8192;
            3'h6: wdt_limit = `WDT_DIV32768;
            default: wdt_limit = `WDT_DIV131072;
        endcase
    endfunction : wdt_limit

    logic [16:0] divCount;       // free divide counter
    wire [16:0] limit = wdt_limit(cks);
    wire [16:0] next_divCount;

    assign tick = run && (divCount == limit);
    // held at zero while stopped so the first period is whole
    assign next_divCount = (!run || tick) ? 17'h00000 : divCount + 17'h00001;

    // divide counter
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            divCount <= 17'h00000;
        else
            divCount <= next_divCount;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    stop_no_tick_a: assert property (!run |=> divCount == 17'h00000)
        else $error("prescaler not held while stopped");
    // a stop in the middle of a period must not be mistaken for a missing tick
    div2_rate_a: assert property (run && cks == 3'h0 ##1 run && cks == 3'h0 |-> tick != $past(tick))
        else $error("divide by two rate wrong");

endmodule : wdt_prescaler

`default_nettype wire

// file: rtl/wdt_timer.sv
/*
 * watchdog / interval timer: keyed register access, 8-bit counter,
 * overflow flags, interval interrupt, internal reset pulse and the
 * standby gate.
 * assumes a cpu bus strobe per access on the peripheral clock, and
 * resetn driven from the external reset pin.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"

module wdt_timer
    import wdt_pkg::*;
(
    input wire logic clock,             // peripheral clock, 250 MHz
    input wire logic resetn,            // external reset pin, async, active low
    input wire wdt_bus_req_t busReq,    // cpu access
    output logic [7:0] busRdata,        // read data, one cycle after rd
    input wire logic sleepExec,         // sleep instruction executed, pulse
    input wire logic standbySelect,     // standby select bit of standby control
    output logic intervalIrq,           // interval interrupt request, level
    output logic internalReset,         // chip internal reset, active high
    output logic clockCtrlInit,         // reinitialize system clock control
    output logic enterSleep,            // go to sleep mode, pulse
    output logic enterStandby           // go to software standby, pulse
);

    // register state
    logic [7:0] watchdogCount;          // counter
    logic intervalOvfFlag;              // interval overflow flag
    logic timerModeSelect;              // 1 = watchdog mode
    logic countRun;                     // counting enabled
    wdt_cks_t clockPrescaleSelect;      // divider select
    logic wdOvfFlag;                    // watchdog overflow flag
    logic chipResetEnable;              // overflow resets chip
    logic ovfArm;                       // interval flag seen set by a read
    logic wovfArm;                      // watchdog flag seen set by a read
    wdt_pulse_state_t pulseState;       // reset pulse state
    logic [9:0] pulseCount;             // cycles left in pulse

    // next values
    logic [7:0] next_watchdogCount;
    logic next_intervalOvfFlag;
    logic next_wdOvfFlag;
    logic [7:0] next_busRdata;

    logic tick;                         // increment enable from prescaler

    // address and key decode
    wire wordWr = busReq.wr && busReq.word;
    wire [7:0] wrKey = busReq.wdata[15:8];
    wire [7:0] wrLow = busReq.wdata[7:0];
    wire ctrlAddrWr = wordWr && (busReq.addr == `WDT_ADDR_CTRL);
    wire cntWr = ctrlAddrWr && (wrKey == `WDT_KEY_COUNT);
    wire ctlWr = ctrlAddrWr && (wrKey == `WDT_KEY_CTRL);
    wire rstAddrWr = wordWr && (busReq.addr == `WDT_ADDR_RST_WR);
    wire wovfClrWr = rstAddrWr && (wrKey == `WDT_KEY_CTRL) && (wrLow == `WDT_WD_OVERFLOW_FLAG_CLR_DATA);
    wire rsteWr = rstAddrWr && (wrKey == `WDT_KEY_COUNT);
    wire ctrlRd = busReq.rd && (busReq.addr == `WDT_ADDR_CTRL);
    wire rstRd = busReq.rd && (busReq.addr == `WDT_ADDR_RST_RD);

    // overflow: a write in the same cycle drops the increment
    wire overflow = tick && countRun && !cntWr && (watchdogCount == `WDT_COUNT_TOP);
    wire wdOvf = overflow && timerModeSelect;
    wire itOvf = overflow && !timerModeSelect;
    wire startPulse = wdOvf && chipResetEnable && (pulseState == WDT_PULSE_IDLE);

    // readback images; fixed bits come from the reset pattern
    wire [7:0] ctrlImage = {intervalOvfFlag, timerModeSelect, countRun, 2'b00, clockPrescaleSelect}
        | `WDT_CTRL_FIXED;
    wire [7:0] rstImage = {wdOvfFlag, chipResetEnable, 6'h00} | `WDT_RSTCTL_RESET;

    // divider
    wdt_prescaler u_prescaler (
        .clock(clock),
        .resetn(resetn),
        .run(countRun),
        .cks(clockPrescaleSelect),
        .tick(tick)
    );

    // counter next value
    always_comb
    begin
        if (wdOvf)
            next_watchdogCount = `WDT_COUNT_ZERO;
        else if (!countRun)
            next_watchdogCount = `WDT_COUNT_ZERO;
        else if (cntWr)
            next_watchdogCount = wrLow;
        else if (tick)
            next_watchdogCount = watchdogCount + 8'h01;
        else
            next_watchdogCount = watchdogCount;
    end

    // flags: the set wins over a clear in the same cycle
    always_comb
    begin
        next_intervalOvfFlag = intervalOvfFlag;
        if (wdOvf)
            next_intervalOvfFlag = 1'b0;
        else if (itOvf)
            next_intervalOvfFlag = 1'b1;
        else if (ctlWr && ovfArm && !wrLow[`WDT_CTRL_OVF_BIT])
            next_intervalOvfFlag = 1'b0;
        next_wdOvfFlag = wdOvfFlag;
        if (wdOvf)
            next_wdOvfFlag = 1'b1;
        else if (wovfClrWr && wovfArm)
            next_wdOvfFlag = 1'b0;
    end

    // read data mux, unmapped addresses read zero
    always_comb
    begin
        case (busReq.addr)
            `WDT_ADDR_CTRL: next_busRdata = ctrlImage;
            `WDT_ADDR_COUNT: next_busRdata = watchdogCount;
            `WDT_ADDR_RST_RD: next_busRdata = rstImage;
            default: next_busRdata = 8'h00;
        endcase
    end

    // counter and flags
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            watchdogCount <= 8'h00;
            intervalOvfFlag <= 1'b0;
            wdOvfFlag <= 1'b0;
        end
        else
        begin
            watchdogCount <= next_watchdogCount;
            intervalOvfFlag <= next_intervalOvfFlag;
            wdOvfFlag <= next_wdOvfFlag;
        end
    end

    // timer control fields; a watchdog overflow returns them to reset
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            timerModeSelect <= 1'b0;
            countRun <= 1'b0;
            clockPrescaleSelect <= 3'h0;
        end
        else if (wdOvf)
        begin
            timerModeSelect <= 1'b0;
            countRun <= 1'b0;
            clockPrescaleSelect <= 3'h0;
        end
        else if (ctlWr)
        begin
            timerModeSelect <= wrLow[`WDT_CTRL_MODE_BIT];
            countRun <= wrLow[`WDT_CTRL_RUN_BIT];
            clockPrescaleSelect <= wrLow[2:0];
        end
    end

    // reset control: only the pin resets it, never the pulse
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            chipResetEnable <= 1'b0;
        else if (rsteWr)
            chipResetEnable <= wrLow[`WDT_RST_CHIP_RESET_ENABLE_BIT];
    end

    // read-before-clear arming; a later write consumes the arm
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ovfArm <= 1'b0;
            wovfArm <= 1'b0;
        end
        else
        begin
            if (ctrlRd && intervalOvfFlag)
                ovfArm <= 1'b1;
            else if (ctlWr || !intervalOvfFlag)
                ovfArm <= 1'b0;
            if (rstRd && wdOvfFlag)
                wovfArm <= 1'b1;
            else if (wovfClrWr || !wdOvfFlag)
                wovfArm <= 1'b0;
        end
    end

    // internal reset pulse generator
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pulseState <= WDT_PULSE_IDLE;
            pulseCount <= 10'h000;
        end
        else
        begin
            case (pulseState)
                WDT_PULSE_IDLE:
                begin
                    if (startPulse)
                    begin
                        pulseState <= WDT_PULSE_ACTIVE;
                        pulseCount <= `WDT_RST_PULSE_CYCLES - 10'h001;
                    end
                end
                WDT_PULSE_ACTIVE:
                begin
                    if (pulseCount == 10'h000)
                        pulseState <= WDT_PULSE_IDLE;
                    else
                        pulseCount <= pulseCount - 10'h001;
                end
                default:
                    pulseState <= WDT_PULSE_IDLE;
            endcase
        end
    end

    // read data register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            busRdata <= 8'h00;
        else if (busReq.rd)
            busRdata <= next_busRdata;
    end

    // outputs
    assign intervalIrq = intervalOvfFlag;
    assign internalReset = pulseState[1];
    assign clockCtrlInit = pulseState[1];
    // a running watchdog would wake nothing from standby, so fall back to sleep
    wire wdRunning = countRun && timerModeSelect;
    assign enterSleep = sleepExec && (!standbySelect || wdRunning);
    assign enterStandby = sleepExec && standbySelect && !wdRunning;

    // helper: length of the current internal reset pulse
    logic [9:0] highCount;
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            highCount <= 10'h000;
        else if (internalReset)
            highCount <= highCount + 10'h001;
        else
            highCount <= 10'h000;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence pulseTrigger;
        wdOvf && chipResetEnable && !internalReset;
    endsequence
    sequence pulseHeld;
        internalReset [*8];
    endsequence

    stop_clears_count_a: assert property (!countRun |=> watchdogCount == 8'h00)
        else $error("counter not zero while stopped");
    wd_flag_set_a: assert property (wdOvf |=> wdOvfFlag && !countRun && watchdogCount == 8'h00)
        else $error("watchdog overflow effects missing");
    irq_on_ovf_a: assert property (itOvf |=> intervalIrq && intervalOvfFlag && !$rose(wdOvfFlag))
        else $error("interval overflow did not raise request");
    pulse_start_a: assert property (pulseTrigger |=> pulseHeld)
        else $error("internal reset did not start");
    pulse_len_a: assert property ($fell(internalReset) |-> $past(highCount) == 10'h206)
        else $error("internal reset length wrong");
    no_chip_reset_a: assert property (wdOvf && !chipResetEnable && !internalReset |=> !internalReset)
        else $error("reset issued with enable clear");
    write_wins_a: assert property (cntWr && countRun |=> watchdogCount == $past(busReq.wdata[7:0]))
        else $error("counter write lost to increment");
    byte_ignored_a: assert property (busReq.wr && !busReq.word && !wdOvf |=>
        $stable({timerModeSelect, countRun, clockPrescaleSelect, chipResetEnable}))
        else $error("byte write changed a register");
    wd_overflow_flag_hold_a: assert property (wdOvfFlag && !wovfArm |=> wdOvfFlag)
        else $error("watchdog flag cleared without read");
    standby_block_a: assert property (sleepExec && standbySelect && countRun && timerModeSelect
        |-> enterSleep && !enterStandby)
        else $error("standby entered with watchdog running");

endmodule : wdt_timer

`default_nettype wire

// file: testbench/watchdog_interval_timer_tb_top.sv
/*
 * self-checking bench for the watchdog interval timer: register map,
 * keyed writes, both timer modes, divider codes, reset pulse, standby gate.
 * assumes wdt_timer as the device and wdt_regs.svh on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdt_regs.svh"

module watchdog_interval_timer_tb_top
    import wdt_pkg::*;
;
    logic clock; // peripheral clock
    logic resetn; // external reset pin
    wdt_bus_req_t busReq; // cpu access driven by the bench
    logic [7:0] busRdata; // registered read data
    logic sleepExec, standbySelect; // sleep instruction and standby bit
    logic intervalIrq, internalReset, clockCtrlInit, enterSleep, enterStandby;
    logic [7:0] expQ[$]; // expected read data, oldest first
    logic rdPend; // a read was taken at the previous edge
    int mismatches, nCompared, i, cnt;
    integer seed; // random seed
    logic [7:0] rv; // random counter refresh value
    int divs[8] = '{2, 64, 128, 512, 2048, 8192, 32768, 131072};

    wdt_timer u_dut (
        .clock(clock),
        .resetn(resetn),
        .busReq(busReq),
        .busRdata(busRdata),
        .sleepExec(sleepExec),
        .standbySelect(standbySelect),
        .intervalIrq(intervalIrq),
        .internalReset(internalReset),
        .clockCtrlInit(clockCtrlInit),
        .enterSleep(enterSleep),
        .enterStandby(enterStandby)
    );

    // 4 ns clock
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // one comparison, counted
    task automatic check_val(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check_val

    // verdict and end of run
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // one write, request held across exactly one rising edge
    task automatic bus_wr(input logic [15:0] addr, input logic [15:0] data, input logic word);
        @(negedge clock);
        busReq.addr = addr;
        busReq.wdata = data;
        busReq.word = word;
        busReq.wr = 1'b1;
        @(negedge clock);
        busReq.wr = 1'b0;
    endtask : bus_wr

    // one read; the monitor compares the answer a cycle later
    task automatic bus_rd(input logic [15:0] addr, input logic [7:0] exp);
        @(negedge clock);
        busReq.addr = addr;
        busReq.rd = 1'b1;
        expQ.push_back(exp);
        @(negedge clock);
        busReq.rd = 1'b0;
    endtask : bus_rd

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle

    // bounded wait for the irq (0) or the internal reset (1)
    task automatic wait_high(input int which, input int bound);
        int k;
        k = 0;
        while (((which == 0) ? intervalIrq : internalReset) !== 1'b1)
        begin
            if (k == bound)
            begin
                mismatches++;
                $display("BAD %0t: wait ran out", $time);
                finish_test();
            end
            k++;
            @(negedge clock);
        end
    endtask : wait_high

    // sleep pulse; the gate is combinational so look in the same cycle
    task automatic do_sleep(input logic sel, input logic expSleep, input logic expStby);
        @(negedge clock);
        standbySelect = sel;
        sleepExec = 1'b1;
        #1;
        check_val({7'h0, enterSleep}, {7'h0, expSleep});
        check_val({7'h0, enterStandby}, {7'h0, expStby});
        @(negedge clock);
        sleepExec = 1'b0;
    endtask : do_sleep

    // monitor: read data stands one cycle after the read edge
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rdPend <= 1'b0;
        else
        begin
            if (rdPend && expQ.size() > 0)
                check_val(busRdata, expQ.pop_front());
            rdPend <= busReq.rd;
        end
    end

    // main sequence
    initial
    begin
        seed = 29;
        mismatches = 0;
        nCompared = 0;
        resetn = 1'b0;
        sleepExec = 1'b0;
        standbySelect = 1'b0;
        busReq = '0;
        idle(5);
        resetn = 1'b1;
        // reset values, read map, unmapped read
        bus_rd(`WDT_ADDR_CTRL, 8'h18);
        bus_rd(`WDT_ADDR_COUNT, 8'h00);
        bus_rd(`WDT_ADDR_RST_RD, 8'h1f);
        bus_rd(`WDT_ADDR_RST_WR, 8'h00);
        // byte writes and a wrong key must change nothing
        bus_wr(`WDT_ADDR_CTRL, 16'ha520, 1'b0);
        bus_wr(`WDT_ADDR_RST_WR, 16'h5a40, 1'b0);
        bus_wr(`WDT_ADDR_CTRL, 16'h3320, 1'b1);
        bus_rd(`WDT_ADDR_CTRL, 8'h18);
        bus_rd(`WDT_ADDR_RST_RD, 8'h1f);
        $display("test reset_map done");
        // interval mode at /2, counter loaded near the top
        bus_wr(`WDT_ADDR_CTRL, 16'ha520, 1'b1);
        do_sleep(1'b1, 1'b0, 1'b1);
        bus_wr(`WDT_ADDR_CTRL - 16'h0 , {`WDT_KEY_COUNT, 8'hfc}, 1'b1);
        wait_high(0, 40);
        bus_rd(`WDT_ADDR_CTRL, 8'hb8);
        bus_rd(`WDT_ADDR_RST_RD, 8'h1f);
        check_val({7'h0, intervalIrq}, 8'h01);
        bus_wr(`WDT_ADDR_CTRL, 16'ha520, 1'b1);
        check_val({7'h0, intervalIrq}, 8'h00);
        // second overflow: a clearing write without a prior read is ignored
        wait_high(0, 600);
        bus_wr(`WDT_ADDR_CTRL, 16'ha520, 1'b1);
        check_val({7'h0, intervalIrq}, 8'h01);
        bus_rd(`WDT_ADDR_CTRL, 8'hb8);
        bus_wr(`WDT_ADDR_CTRL, 16'ha500, 1'b1);
        check_val({7'h0, intervalIrq}, 8'h00);
        bus_rd(`WDT_ADDR_COUNT, 8'h00);
        do_sleep(1'b0, 1'b1, 1'b0);
        $display("test interval done");
        // divider codes 1 to 7; the long ones only show no early tick
        for (i = 1; i < 8; i++)
        begin
            bus_wr(`WDT_ADDR_CTRL, {8'ha5, 8'h20 | 8'(i)}, 1'b1);
            if (i < 5)
            begin
                idle(3 * divs[i] + divs[i] / 2);
                bus_rd(`WDT_ADDR_COUNT, 8'h03);
            end
            else
            begin
                idle(1000);
                bus_rd(`WDT_ADDR_COUNT, 8'h00);
            end
            bus_rd(`WDT_ADDR_CTRL, 8'h38 | 8'(i));
            // stop before the next code is chosen
            bus_wr(`WDT_ADDR_CTRL, {8'ha5, 8'(i)}, 1'b1);
        end
        $display("test dividers done");
        // watchdog mode without chip reset; the timer was stopped before the mode switch
        bus_wr(`WDT_ADDR_RST_WR, 16'h5a00, 1'b1);
        bus_wr(`WDT_ADDR_CTRL, 16'ha560, 1'b1);
        do_sleep(1'b1, 1'b1, 1'b0);
        bus_wr(`WDT_ADDR_COUNT - 16'h1, {`WDT_KEY_COUNT, 8'hf0}, 1'b1);
        idle(60);
        check_val({6'h0, internalReset, clockCtrlInit}, 8'h00);
        bus_rd(`WDT_ADDR_RST_RD, 8'h9f);
        bus_rd(`WDT_ADDR_CTRL, 8'h18);
        bus_rd(`WDT_ADDR_COUNT, 8'h00);
        // key 5a touches only the enable, key a5 with zero clears the flag
        bus_wr(`WDT_ADDR_RST_WR, 16'h5aff, 1'b1);
        bus_rd(`WDT_ADDR_RST_RD, 8'hdf);
        bus_wr(`WDT_ADDR_RST_WR, 16'h5a00, 1'b1);
        bus_rd(`WDT_ADDR_RST_RD, 8'h9f);
        // clearing key with a nonzero low byte is refused
        bus_wr(`WDT_ADDR_RST_WR, 16'ha501, 1'b1);
        bus_rd(`WDT_ADDR_RST_RD, 8'h9f);
        bus_wr(`WDT_ADDR_RST_WR, 16'ha500, 1'b1);
        bus_rd(`WDT_ADDR_RST_RD, 8'h1f);
        $display("test watchdog_noreset done");
        // chip reset enabled; random refreshes keep it quiet
        bus_wr(`WDT_ADDR_RST_WR, 16'h5a40, 1'b1);
        bus_wr(`WDT_ADDR_CTRL, 16'ha560, 1'b1);
        for (i = 0; i < 8; i++)
        begin
            rv = 8'($random(seed));
            bus_wr(`WDT_ADDR_CTRL, {`WDT_KEY_COUNT, rv & 8'h7f}, 1'b1);
            idle(200);
            check_val({7'h0, internalReset}, 8'h00);
        end
        // no more refreshes: the pulse must last its full length
        wait_high(1, 600);
        check_val({7'h0, clockCtrlInit}, 8'h01);
        cnt = 0;
        while (internalReset === 1'b1 && cnt < 700)
        begin
            cnt++;
            @(negedge clock);
        end
        check_val(8'(cnt / 4), 8'(519 / 4));
        check_val(8'(cnt % 4), 8'(519 % 4));
        bus_rd(`WDT_ADDR_RST_RD, 8'hdf);
        $display("test watchdog_reset done");
        // pin reset in the middle of a pulse wins and clears the flag
        bus_wr(`WDT_ADDR_CTRL, 16'ha560, 1'b1);
        bus_wr(`WDT_ADDR_CTRL, {`WDT_KEY_COUNT, 8'hf8}, 1'b1);
        wait_high(1, 100);
        idle(10);
        resetn = 1'b0;
        #1;
        check_val({7'h0, internalReset}, 8'h00);
        idle(2);
        resetn = 1'b1;
        bus_rd(`WDT_ADDR_RST_RD, 8'h1f);
        bus_rd(`WDT_ADDR_CTRL, 8'h18);
        idle(3);
        $display("test pin_reset done");
        finish_test();
    end
endmodule : watchdog_interval_timer_tb_top

`default_nettype wire
